// *** design/bms_coef_mem.sv ***
// coefficient store: one write port, one read port with registered data
// assumes writer and reader on the same clock; contents are not reset
module bms_coef_mem
    import bms_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [COEF_AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [COEF_AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [COEF_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : bms_coef_mem

// *** design/bms_pkg.sv ***
// constants, types and state carriers for the bridge measurement sequencer
// assumes one 20 MHz clock and a synchronous active-high reset
package bms_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int STARTUP_WINDOW_US = 10_000;
    localparam int STARTUP_WINDOW_CYC = STARTUP_WINDOW_US * (CLK_HZ / 1_000_000);
    localparam int CHOP_PERIOD_NS = 2_000;
    localparam int CHOP_PERIOD_CYC = (CHOP_PERIOD_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
    localparam int CMD_PULSES = 4;

    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_CLAMP_LO = 8'h04;
    localparam logic [7:0] ADDR_CLAMP_HI = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_PRES_RES = 8'h10;
    localparam logic [7:0] ADDR_TEMP_RES = 8'h14;
    localparam logic [7:0] ADDR_DAC_CODE = 8'h18;
    localparam logic [1:0] COEF_PAGE = 2'h1;

    localparam int CFG_GAIN_LSB = 0;
    localparam int CFG_CHOP = 2;
    localparam int CFG_ZSHIFT_LSB = 3;
    localparam int CFG_BRIDGE_INV = 5;
    localparam int CFG_TEMP_EXT = 6;
    localparam int CFG_TEMP_EN = 7;
    localparam int CFG_OUT_DIGITAL = 8;
    localparam int CFG_WIRE_CALIB = 9;
    localparam int CFG_BUF_OFS_DIS = 10;
    localparam logic [15:0] CFG_RESET = 16'h0080;
    localparam logic [11:0] CLAMP_LO_RESET = 12'h000;
    localparam logic [11:0] DAC_MAX = 12'h9FF;

    localparam int COEF_DEPTH = 16;
    localparam int COEF_AW = 4;
    localparam int DW = 16;

    typedef enum logic [1:0] {
        SRC_EXT_DIODE = 2'h0,
        SRC_INT_JUNCTION = 2'h1,
        SRC_SHORT = 2'h2,
        SRC_BRIDGE = 2'h3
    } bms_src_t;

    typedef enum logic [2:0] {
        ST_S_PRES = 3'h0,
        ST_S_PAZ = 3'h1,
        ST_S_TEMP = 3'h2,
        ST_S_TAZ = 3'h3,
        ST_L_PRES1 = 3'h4,
        ST_L_TEMP = 3'h5,
        ST_L_PRES2 = 3'h6,
        ST_L_PAZ = 3'h7
    } bms_step_t;

    typedef struct packed {
        logic [1:0] gain;
        logic chop_en;
        logic chop_phase;
        logic [1:0] zero_shift;
        logic bridge_inv;
        bms_src_t src;
        logic temp_cur_en;
        logic adc_start;
    } bms_afe_t;

    typedef struct packed {
        bms_step_t step;
        logic busy;
        logic start;
        logic chop_phase;
        logic [7:0] chop_cnt;
        logic [15:0] cfg;
        logic [11:0] clamp_lo;
        logic [11:0] clamp_hi;
        logic [15:0] pres_az;
        logic [15:0] temp_az;
        logic [15:0] pres_res;
        logic [15:0] temp_res;
        logic [11:0] dac;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic [2:0] pulse_cnt;
        logic cmd_mode;
        logic window;
        logic [23:0] win_cnt;
        logic [15:0] rdata;
        logic rsel_mem;
        logic [15:0] ldata;
        logic lsel_mem;
    } bms_state_t;
endpackage : bms_pkg

// *** design/bms_sequencer.sv ***
// bridge measurement sequencer: source stepping, settings, results, clamp, pin mode
// assumes an adc that answers each start with one done pulse, and an outside wire engine
//
// Decided for this implementation: the strobed register port and the register addresses.
module bms_sequencer
    import bms_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_WINDOW_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [7:0] BUS_ADDR,
    input wire logic [15:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    output logic [15:0] BUS_RDATA,
    output bms_afe_t AFE_CTRL,
    input wire logic ADC_DONE,
    input wire logic [15:0] ADC_DATA,
    input wire logic CORR_VALID,
    input wire logic [11:0] CORR_VALUE,
    output logic [11:0] DAC_CODE,
    output logic ANALOG_DRV_EN,
    output logic BUF_OFS_CORR_EN,
    output logic WIRE_CALIB_MODE,
    output logic CMD_MODE,
    input wire logic PIN_IN,
    output logic PIN_OUT,
    output logic PIN_OE,
    input wire logic WIRE_TX_DATA,
    input wire logic WIRE_TX_EN,
    input wire logic WIRE_WR,
    input wire logic WIRE_RD,
    input wire logic [7:0] WIRE_ADDR,
    input wire logic [15:0] WIRE_WDATA,
    output logic [15:0] WIRE_RDATA
);
    bms_state_t q;
    bms_state_t d;
    logic [15:0] mem_rdata;
    logic mem_we;
    logic [COEF_AW-1:0] mem_waddr;
    logic [COEF_AW-1:0] mem_raddr;
    logic [15:0] mem_wdata;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;
    logic wr_en;
    logic wire_wr_ok;
    logic wire_rd_ok;
    logic [15:0] diff;
    logic [11:0] clamped;

    function automatic logic [15:0] reg_read(input bms_state_t s, input logic [7:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            ADDR_CONFIG: v = s.cfg;
            ADDR_CLAMP_LO: v = {4'h0, s.clamp_lo};
            ADDR_CLAMP_HI: v = {4'h0, s.clamp_hi};
            ADDR_STATUS: v = {10'h000, s.window, s.cmd_mode, s.busy, s.step};
            ADDR_PRES_RES: v = s.pres_res;
            ADDR_TEMP_RES: v = s.temp_res;
            ADDR_DAC_CODE: v = {4'h0, s.dac};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : reg_read

    function automatic bms_step_t next_step(input bms_step_t s, input logic temp_en);
        bms_step_t n;
        n = ST_L_PRES1;
        case (s)
            ST_S_PRES: n = ST_S_PAZ;
            ST_S_PAZ: n = temp_en ? ST_S_TEMP : ST_L_PRES1;
            ST_S_TEMP: n = ST_S_TAZ;
            ST_S_TAZ: n = ST_L_PRES1;
            ST_L_PRES1: n = temp_en ? ST_L_TEMP : ST_L_PRES2;
            ST_L_TEMP: n = ST_L_PRES2;
            ST_L_PRES2: n = ST_L_PAZ;
            ST_L_PAZ: n = ST_L_PRES1;
            default: n = ST_S_PRES;
        endcase
        return n;
    endfunction : next_step

    // wire access only once command mode has been entered at power-up
    assign wire_wr_ok = WIRE_WR && q.cmd_mode;
    assign wire_rd_ok = WIRE_RD && q.cmd_mode;
    // the bus wins a same-cycle write; the wire engine must retry
    assign wr_en = BUS_WR || wire_wr_ok;
    assign wr_addr = BUS_WR ? BUS_ADDR : WIRE_ADDR;
    assign wr_data = BUS_WR ? BUS_WDATA : WIRE_WDATA;
    assign mem_we = wr_en && (wr_addr[7:6] == COEF_PAGE) && (wr_addr[1:0] == 2'h0);
    assign mem_waddr = wr_addr[5:2];
    assign mem_wdata = wr_data;
    assign mem_raddr = BUS_RD ? BUS_ADDR[5:2] : WIRE_ADDR[5:2];
    assign diff = ADC_DATA - (q.step == ST_S_TEMP || q.step == ST_L_TEMP ? q.temp_az : q.pres_az);

    always_comb begin
        clamped = CORR_VALUE;
        if (CORR_VALUE > q.clamp_hi) begin
            clamped = q.clamp_hi;
        end else if (CORR_VALUE < q.clamp_lo) begin
            clamped = q.clamp_lo;
        end
        if (clamped > DAC_MAX) begin
            clamped = DAC_MAX;
        end
    end

    always_comb begin
        d = q;
        d.start = 1'b0;
        // measurement stepping
        if (!q.busy) begin
            d.busy = 1'b1;
            d.start = 1'b1;
            d.chop_cnt = 8'h00;
        end else if (ADC_DONE) begin
            d.busy = 1'b0;
            case (q.step)
                ST_S_PRES, ST_L_PRES1, ST_L_PRES2: d.pres_res = diff;
                ST_S_TEMP, ST_L_TEMP: d.temp_res = diff;
                ST_S_PAZ, ST_L_PAZ: d.pres_az = ADC_DATA;
                ST_S_TAZ: d.temp_az = ADC_DATA;
                default: d.pres_az = q.pres_az;
            endcase
            d.step = next_step(q.step, q.cfg[CFG_TEMP_EN]);
        end
        // chopper divider runs only inside a conversion
        if (q.busy && q.cfg[CFG_CHOP]) begin
            if (q.chop_cnt == 8'(CHOP_PERIOD_CYC - 1)) begin
                d.chop_cnt = 8'h00;
                d.chop_phase = ~q.chop_phase;
            end else begin
                d.chop_cnt = q.chop_cnt + 8'h01;
            end
        end else if (!q.cfg[CFG_CHOP]) begin
            d.chop_phase = 1'b0;
        end
        // power-up window: pin released, pulses counted
        d.pin_s1 = PIN_IN;
        d.pin_s2 = q.pin_s1;
        d.pin_prev = q.pin_s2;
        if (q.window) begin
            if (q.win_cnt == 24'(STARTUP_CYCLES - 1)) begin
                d.window = 1'b0;
            end else begin
                d.win_cnt = q.win_cnt + 24'h000001;
            end
            if (q.pin_prev && !q.pin_s2 && q.pulse_cnt != 3'(CMD_PULSES)) begin
                d.pulse_cnt = q.pulse_cnt + 3'h1;
            end
            if (q.pulse_cnt == 3'(CMD_PULSES)) begin
                d.cmd_mode = 1'b1;
            end
        end
        if (CORR_VALID) begin
            d.dac = clamped;
        end
        // register writes from bus or wire
        if (wr_en) begin
            case (wr_addr)
                ADDR_CONFIG: d.cfg = wr_data;
                ADDR_CLAMP_LO: d.clamp_lo = wr_data[11:0];
                ADDR_CLAMP_HI: d.clamp_hi = wr_data[11:0];
                default: d.cfg = d.cfg;
            endcase
        end
        d.rdata = reg_read(q, BUS_ADDR);
        d.rsel_mem = BUS_RD && (BUS_ADDR[7:6] == COEF_PAGE);
        d.ldata = wire_rd_ok ? reg_read(q, WIRE_ADDR) : 16'h0000;
        d.lsel_mem = wire_rd_ok && !BUS_RD && (WIRE_ADDR[7:6] == COEF_PAGE);
        if (!BUS_RD) begin
            d.rdata = 16'h0000;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            q <= '0;
            q.step <= ST_S_PRES;
            q.cfg <= CFG_RESET;
            q.clamp_lo <= CLAMP_LO_RESET;
            q.clamp_hi <= DAC_MAX;
            q.window <= 1'b1;
        end else begin
            q <= d;
        end
    end

    bms_coef_mem u_coef_mem (
        .clk(CLK_SYS),
        .rst(RESET),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    always_comb begin
        AFE_CTRL.gain = q.cfg[CFG_GAIN_LSB +: 2];
        AFE_CTRL.chop_en = q.cfg[CFG_CHOP];
        AFE_CTRL.chop_phase = q.chop_phase;
        AFE_CTRL.zero_shift = q.cfg[CFG_ZSHIFT_LSB +: 2];
        AFE_CTRL.bridge_inv = q.cfg[CFG_BRIDGE_INV];
        AFE_CTRL.adc_start = q.start;
        AFE_CTRL.temp_cur_en = q.busy && (q.step == ST_S_TEMP || q.step == ST_L_TEMP);
        case (q.step)
            ST_S_TEMP, ST_L_TEMP: AFE_CTRL.src = q.cfg[CFG_TEMP_EXT] ? SRC_EXT_DIODE : SRC_INT_JUNCTION;
            ST_S_PAZ, ST_S_TAZ, ST_L_PAZ: AFE_CTRL.src = SRC_SHORT;
            default: AFE_CTRL.src = SRC_BRIDGE;
        endcase
    end

    // analog drive stays off through the window so start pulses can be seen
    assign ANALOG_DRV_EN = !q.window && !q.cmd_mode && !q.cfg[CFG_OUT_DIGITAL];
    assign PIN_OE = !q.window && (q.cmd_mode || q.cfg[CFG_OUT_DIGITAL]) && WIRE_TX_EN;
    assign PIN_OUT = WIRE_TX_DATA;
    assign BUF_OFS_CORR_EN = !q.cfg[CFG_BUF_OFS_DIS];
    assign WIRE_CALIB_MODE = q.cfg[CFG_WIRE_CALIB];
    assign CMD_MODE = q.cmd_mode;
    assign DAC_CODE = q.dac;
    assign BUS_RDATA = q.rsel_mem ? mem_rdata : q.rdata;
    assign WIRE_RDATA = q.lsel_mem ? mem_rdata : q.ldata;
endmodule : bms_sequencer

// *** verification/bms_adc_model.sv ***
// sensor and converter stand-in: one done pulse per start
// assumes afe control from the sequencer; sample fixed per source
module bms_adc_model
    import bms_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire bms_afe_t afe,
    output logic done,
    output logic [15:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    bms_src_t src;
    always_ff @(posedge clk) begin
        done <= 1'b0;
        // data only valid with done, so it churns otherwise
        data <= ~data;
        if (rst) begin
            cnt <= 0;
            data <= 16'h5A5A;
        end else if (afe.adc_start) begin
            // slow conversions outlast two chopper periods
            cnt <= slow ? 100 : 3;
            src <= afe.src;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            done <= 1'b1;
            data <= {src, 14'h0100};
        end
    end
endmodule : bms_adc_model

// *** verification/bms_seq_asserts.sv ***
// checker: settings, clamp and pin relations at the sequencer ports
// assumes binding into bms_sequencer; settings shadowed from bus writes only
module bms_seq_asserts
    import bms_pkg::*;
#(
    parameter int STARTUP_CYCLES = 200
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [7:0] BUS_ADDR,
    input wire logic [15:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire bms_afe_t AFE_CTRL,
    input wire logic CORR_VALID,
    input wire logic [11:0] CORR_VALUE,
    input wire logic [11:0] DAC_CODE,
    input wire logic ANALOG_DRV_EN,
    input wire logic BUF_OFS_CORR_EN,
    input wire logic WIRE_CALIB_MODE,
    input wire logic CMD_MODE,
    input wire logic PIN_OE,
    input wire logic WIRE_TX_EN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cfg_q, cfg_p;
    logic [11:0] lo_q, hi_q;
    int win_q;
    // one settled cycle after a write, since outputs may be registered
    wire st = cfg_q == cfg_p;
    wire up = win_q > STARTUP_CYCLES + 2;
    wire [11:0] lim = CORR_VALUE > hi_q ? hi_q : (CORR_VALUE < lo_q ? lo_q : CORR_VALUE);
    wire [11:0] cexp = lim > DAC_MAX ? DAC_MAX : lim;
    always_ff @(posedge CLK_SYS) begin
        cfg_p <= RESET ? CFG_RESET : cfg_q;
        if (RESET) begin
            cfg_q <= CFG_RESET;
            lo_q <= CLAMP_LO_RESET;
            hi_q <= DAC_MAX;
            win_q <= 0;
        end else begin
            win_q <= win_q < STARTUP_CYCLES + 8 ? win_q + 1 : win_q;
            if (BUS_WR && BUS_ADDR == ADDR_CONFIG) cfg_q <= BUS_WDATA;
            if (BUS_WR && BUS_ADDR == ADDR_CLAMP_LO) lo_q <= BUS_WDATA[11:0];
            if (BUS_WR && BUS_ADDR == ADDR_CLAMP_HI) hi_q <= BUS_WDATA[11:0];
        end
    end
    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);
    a_gain_set: assert property (st |-> AFE_CTRL.gain == cfg_q[1:0]) else $error("gain off setting");
    a_zero_shift: assert property (st |-> AFE_CTRL.zero_shift == cfg_q[4:3]) else $error("shift off");
    a_bridge_pol: assert property (st |-> AFE_CTRL.bridge_inv == cfg_q[5]) else $error("polarity off");
    a_chop_idle: assert property (st && !cfg_q[2] |-> !AFE_CTRL.chop_phase) else $error("chop moves");
    a_chop_en: assert property (st |-> AFE_CTRL.chop_en == cfg_q[2]) else $error("chop enable off");
    a_temp_current: assert property (AFE_CTRL.temp_cur_en |->
        AFE_CTRL.src inside {SRC_EXT_DIODE, SRC_INT_JUNCTION}) else $error("current on outside temperature");
    a_dac_clamp: assert property (CORR_VALID |=> DAC_CODE == $past(cexp)) else $error("clamp wrong");
    a_start_quiet: assert property (win_q < STARTUP_CYCLES - 1 |-> !ANALOG_DRV_EN && !PIN_OE)
        else $error("pin driven in window");
    a_out_mode: assert property (up && st && $stable(CMD_MODE) && $stable(WIRE_TX_EN) |->
        ANALOG_DRV_EN == (!CMD_MODE && !cfg_q[8]) && PIN_OE == ((CMD_MODE || cfg_q[8]) && WIRE_TX_EN))
        else $error("output mode wrong");
    a_wire_mode: assert property (st |-> WIRE_CALIB_MODE == cfg_q[9]) else $error("wire mode off");
    a_buf_ofs: assert property (st |-> BUF_OFS_CORR_EN == !cfg_q[10]) else $error("buffer corr off");
    c_corr: cover property (CORR_VALID);
    c_cmd: cover property (CMD_MODE && PIN_OE);
    c_temp: cover property (AFE_CTRL.temp_cur_en);
endmodule : bms_seq_asserts

bind bms_sequencer bms_seq_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) bms_seq_asserts_inst (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR),
    .AFE_CTRL(AFE_CTRL), .CORR_VALID(CORR_VALID), .CORR_VALUE(CORR_VALUE), .DAC_CODE(DAC_CODE),
    .ANALOG_DRV_EN(ANALOG_DRV_EN), .BUF_OFS_CORR_EN(BUF_OFS_CORR_EN), .WIRE_CALIB_MODE(WIRE_CALIB_MODE),
    .CMD_MODE(CMD_MODE), .PIN_OE(PIN_OE), .WIRE_TX_EN(WIRE_TX_EN)
);

// *** verification/testbench.sv ***
// top bench: bus, wire port, pin master and corrections against the sequencer
// assumes the converter stand-in and a 200-cycle power-up window
module testbench
    import bms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SU = 200;
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, wwr = 1'b0, wrd = 1'b0, cv = 1'b0;
    logic done, drv, bofs, wcal, cmd, pout, poe, txd = 1'b0, txen = 1'b0, mdrv = 1'b1, slow = 1'b0, ph;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, adata, wrdata;
    logic [11:0] cval = 12'h000, dac;
    logic [11:0] cin[4] = '{12'h050, 12'h900, 12'h400, 12'hFFF};
    logic [11:0] cexp[4] = '{12'h100, 12'h800, 12'h400, 12'h9FF};
    bms_src_t seq[8] = '{SRC_BRIDGE, SRC_SHORT, SRC_INT_JUNCTION, SRC_SHORT,
        SRC_BRIDGE, SRC_INT_JUNCTION, SRC_BRIDGE, SRC_SHORT};
    bms_afe_t afe;
    bms_src_t srcq[$];
    int fail_count = 0, comparisons = 0, n;
    // pulled-up line: master releases high
    wire pin = poe ? pout : mdrv;
    bms_sequencer #(.STARTUP_CYCLES(SU)) bms_sequencer_inst (
        .CLK_SYS(clk), .RESET(rst), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr_s), .BUS_RD(rd_s),
        .BUS_RDATA(rdata), .AFE_CTRL(afe), .ADC_DONE(done), .ADC_DATA(adata), .CORR_VALID(cv),
        .CORR_VALUE(cval), .DAC_CODE(dac), .ANALOG_DRV_EN(drv), .BUF_OFS_CORR_EN(bofs),
        .WIRE_CALIB_MODE(wcal), .CMD_MODE(cmd), .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE(poe),
        .WIRE_TX_DATA(txd), .WIRE_TX_EN(txen), .WIRE_WR(wwr), .WIRE_RD(wrd), .WIRE_ADDR(addr),
        .WIRE_WDATA(wdata), .WIRE_RDATA(wrdata)
    );
    bms_adc_model bms_adc_model_inst (
        .clk(clk), .rst(rst), .slow(slow), .afe(afe), .done(done), .data(adata)
    );
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst) srcq.delete();
        else if (afe.adc_start) srcq.push_back(afe.src);
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic w);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wwr <= w;
        wr_s <= !w;
        @(posedge clk);
        wwr <= 1'b0;
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic w);
        @(posedge clk);
        addr <= a;
        wrd <= w;
        rd_s <= !w;
        @(posedge clk);
        wrd <= 1'b0;
        rd_s <= 1'b0;
        #1 chk(w ? wrdata : rdata, e);
    endtask : rd
    task automatic wait_src(input bms_src_t s);
        int k;
        for (k = 0; k < 600 && !(afe.adc_start && afe.src == s); k++) begin
            @(posedge clk);
            #1;
        end
        chk({15'h0, k < 600}, 16'h0001);
        if (k >= 600) end_of_test();
    endtask : wait_src
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) begin
            repeat (3) @(posedge clk);
            mdrv <= 1'b0;
            repeat (3) @(posedge clk);
            mdrv <= 1'b1;
        end
        repeat (SU) @(posedge clk);
        txen <= 1'b1;
        txd <= 1'b1;
        @(posedge clk);
        #1 chk({12'h0, pout, cmd, poe, drv}, 16'h000E);
        rd(ADDR_PRES_RES, 16'h4000, 1'b1);
        rd(ADDR_TEMP_RES, 16'hC000, 1'b1);
        wr(8'h44, 16'hBEEF, 1'b1);
        rd(8'h44, 16'hBEEF, 1'b0);
        for (int i = 0; i < 8; i++) begin
            chk(16'(srcq[i]), 16'(seq[i]));
        end
        @(posedge clk);
        txen <= 1'b0;
        slow <= 1'b1;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CONFIG, CFG_RESET, 1'b0);
        rd(ADDR_CLAMP_HI, 16'h09FF, 1'b0);
        rd(8'h20, 16'h0000, 1'b0);
        repeat (SU) @(posedge clk);
        #1 chk({14'h0, cmd, drv}, 16'h0001);
        // result is nonzero by now, so a zero answer proves the wire is shut outside command mode
        rd(ADDR_PRES_RES, 16'h0000, 1'b1);
        wr(ADDR_CONFIG, 16'h06FF, 1'b0);
        @(posedge clk);
        #1 chk({13'h0, wcal, bofs, drv}, 16'h0005);
        wait_src(SRC_EXT_DIODE);
        n = 0;
        for (int j = 0; j < 90; j++) begin
            ph = afe.chop_phase;
            @(posedge clk);
            #1 n += int'(afe.chop_phase != ph);
        end
        chk(16'(n), 16'(90 / CHOP_PERIOD_CYC));
        wr(ADDR_CONFIG, 16'h0100, 1'b0);
        srcq.delete();
        repeat (300) @(posedge clk);
        n = 0;
        foreach (srcq[i]) n += int'(i > 0 && srcq[i] != SRC_BRIDGE && srcq[i] != SRC_SHORT);
        chk(16'(n), 16'h0000);
        #1 chk({15'h0, drv}, 16'h0000);
        wr(ADDR_CLAMP_LO, 16'h0100, 1'b0);
        wr(ADDR_CLAMP_HI, 16'h0800, 1'b0);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) wr(ADDR_CLAMP_HI, 16'h0FFF, 1'b0);
            @(posedge clk);
            cv <= 1'b1;
            cval <= cin[i];
            @(posedge clk);
            cv <= 1'b0;
            #1 chk({4'h0, dac}, {4'h0, cexp[i]});
        end
        end_of_test();
    end
endmodule : testbench
